// file: shared/hcb_pkg.sv
// constants for the hub configuration byte bank
package hcb_pkg;

  // register port geometry
  localparam int           ADDR_W     = 8;
  localparam int           DATA_W     = 8;
  localparam int           PORT_CNT   = 4;
  localparam logic [7:0]   REG_RST    = 8'h00;

  // register offsets
  localparam logic [7:0]   ADDR_STATUS = 8'h00;
  localparam logic [7:0]   ADDR_CFG_A  = 8'h07;
  localparam logic [7:0]   ADDR_CFG_B  = 8'h08;
  localparam logic [7:0]   ADDR_FIXED  = 8'h09;
  localparam logic [7:0]   ADDR_SPOFF  = 8'h0A;
  localparam logic [7:0]   PROT_LO     = 8'h01;
  localparam logic [7:0]   PROT_HI     = 8'h10;

  // first configuration byte fields
  localparam int           CFGA_SUPPLY = 7;
  localparam int           CFGA_LED    = 6;
  localparam int           CFGA_FSONLY = 5;
  localparam int           CFGA_PPTT   = 4;
  localparam int           CFGA_EOPSUP = 3;
  localparam int           CFGA_OCS_HI = 2;
  localparam int           CFGA_OCS_LO = 1;
  localparam int           CFGA_PWRSW  = 0;

  // second configuration byte fields
  localparam int           CFGB_DYN    = 7;
  localparam int           CFGB_OCT_HI = 5;
  localparam int           CFGB_OCT_LO = 4;
  localparam int           CFGB_CMPND  = 3;

  // status/command bits
  localparam int           STAT_SOFTRST = 2;
  localparam int           STAT_LOCK    = 1;

  // writable bit masks, everything else is reserved and reads zero
  localparam logic [7:0]   CFGA_WMASK = 8'hFF;
  localparam logic [7:0]   CFGB_WMASK = 8'hB8;
  localparam logic [7:0]   PORT_WMASK = 8'h1E;
  localparam int           PORT_LSB   = 1;

  // overcurrent sense encodings
  localparam logic [1:0]   OCS_GANGED   = 2'h0;
  localparam logic [1:0]   OCS_PER_PORT = 2'h1;

  // overcurrent delay selections
  localparam logic [1:0]   OCT_SEL0 = 2'h0;
  localparam logic [1:0]   OCT_SEL1 = 2'h1;
  localparam logic [1:0]   OCT_SEL2 = 2'h2;
  localparam logic [1:0]   OCT_SEL3 = 2'h3;

  // timing, times in ns, counts rounded up at the core clock
  localparam int           CLK_PERIOD_NS = 100;
  localparam int           OC_DELAY0_NS  = 100000;
  localparam int           OC_DELAY1_NS  = 2000000;
  localparam int           OC_DELAY2_NS  = 4000000;
  localparam int           OC_DELAY3_NS  = 6000000;
  localparam int           OC_DELAY0_CYC = (OC_DELAY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           OC_DELAY1_CYC = (OC_DELAY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           OC_DELAY2_CYC = (OC_DELAY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           OC_DELAY3_CYC = (OC_DELAY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           OC_CNT_W      = 16;

endpackage

// file: src/hcb_pin_sync.sv
// three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
module hcb_pin_sync
  import hcb_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pinRaw,
  output logic      pinLevel
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;

  // stage1 only feeds stage2; the level moves once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_q  <= 1'b0;
    end else begin
      stage1_q <= pinRaw;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= (stage2_q == stage3_q) ? stage3_q : level_q;
    end
  end

  assign pinLevel = level_q;

endmodule

// file: src/hcb_config_bank.sv
// hub configuration byte bank with lock, soft reset and decoded outputs
`timescale 1ns/1ps
module hcb_config_bank
  import hcb_pkg::*;
#(
  parameter int OC_CYC0 = OC_DELAY0_CYC,
  parameter int OC_CYC1 = OC_DELAY1_CYC,
  parameter int OC_CYC2 = OC_DELAY2_CYC,
  parameter int OC_CYC3 = OC_DELAY3_CYC
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic                  regWrEn,
  input  wire logic [DATA_W-1:0]     regWrData,
  input  wire logic                  regRdEn,
  output logic      [DATA_W-1:0]     regRdData,
  input  wire logic                  localSupplyPresent,
  output logic                       selfPowered,
  output logic                       supplySourceSel,
  output logic                       ledIndicatorSupport,
  output logic                       fullSpeedOnly,
  output logic                       perPortTranslatorEn,
  output logic                       fsFrameEndSuppress,
  output logic      [1:0]            overcurrentSenseMode,
  output logic                       overcurrentSenseOff,
  output logic                       powerSwitchMode,
  output logic                       dynamicSwitchEn,
  output logic      [1:0]            overcurrentDelaySel,
  output logic      [OC_CNT_W-1:0]   overcurrentDelayCycles,
  output logic                       compoundDevice,
  output logic      [PORT_CNT-1:0]   fixedPortMask,
  output logic      [PORT_CNT-1:0]   selfSupplyPortOffMask,
  output logic                       portOffGapErr,
  output logic                       configLock,
  output logic                       serialIfReset
);

  // registers
  logic [DATA_W-1:0]   cfgA_q;
  logic [DATA_W-1:0]   cfgB_q;
  logic [DATA_W-1:0]   fixedMask_q;
  logic [DATA_W-1:0]   spOffMask_q;
  logic                lock_q;
  logic                softRst_q;
  logic [DATA_W-1:0]   rdData_q;
  logic                selfPowered_q;
  logic [OC_CNT_W-1:0] ocCycles_q;
  logic                gapErr_q;
  logic [OC_CNT_W-1:0] ocCycles_d;
  logic [DATA_W-1:0]   rdData_d;

  // decode wires
  wire logic          pinSupply;
  wire logic          inProtRange;
  wire logic          wrOk;
  wire logic          wrStatus;
  wire logic          wrCfgA;
  wire logic          wrCfgB;
  wire logic          wrFixed;
  wire logic          wrSpOff;
  wire logic          effSelfPowered;

  // a write inside 01h-10h is refused while locked; a soft reset pulse also swallows writes
  function automatic logic protAddr(input logic [ADDR_W-1:0] a);
    protAddr = (a >= PROT_LO) && (a <= PROT_HI);
  endfunction

  // non-contiguous pattern: some cleared port lies between two disabled ports
  function automatic logic hasGap(input logic [PORT_CNT-1:0] m);
    hasGap = 1'b0;
    for (int i = 0; i < PORT_CNT; i++) begin
      for (int j = i + 1; j < PORT_CNT; j++) begin
        for (int k = j + 1; k < PORT_CNT; k++) begin
          if (m[i] && !m[j] && m[k]) begin
            hasGap = 1'b1;
          end
        end
      end
    end
  endfunction

  // supply presence pin crossing into the core clock
  hcb_pin_sync u_supplySync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinRaw   (localSupplyPresent),
    .pinLevel (pinSupply)
  );

  // write acceptance
  assign inProtRange = protAddr(regAddr);
  assign wrOk        = regWrEn && !softRst_q && !(lock_q && inProtRange);
  assign wrStatus    = wrOk && (regAddr == ADDR_STATUS);
  assign wrCfgA      = wrOk && (regAddr == ADDR_CFG_A);
  assign wrCfgB      = wrOk && (regAddr == ADDR_CFG_B);
  assign wrFixed     = wrOk && (regAddr == ADDR_FIXED);
  assign wrSpOff     = wrOk && (regAddr == ADDR_SPOFF);

  // the pin overrides the stored supply bit only while dynamic switching is on
  assign effSelfPowered = cfgB_q[CFGB_DYN] ? pinSupply : cfgA_q[CFGA_SUPPLY];

  // configuration storage; soft reset clears them but never the lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgA_q      <= REG_RST;
      cfgB_q      <= REG_RST;
      fixedMask_q <= REG_RST;
      spOffMask_q <= REG_RST;
    end else if (softRst_q) begin
      cfgA_q      <= REG_RST;
      cfgB_q      <= REG_RST;
      fixedMask_q <= REG_RST;
      spOffMask_q <= REG_RST;
    end else begin
      if (wrCfgA) cfgA_q <= regWrData & CFGA_WMASK;
      if (wrCfgB) cfgB_q <= regWrData & CFGB_WMASK;
      if (wrFixed) fixedMask_q <= regWrData & PORT_WMASK;
      if (wrSpOff) spOffMask_q <= regWrData & PORT_WMASK;
    end
  end

  // lock is write-once and only the reset pin drops it; soft reset is a one-cycle pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_q    <= 1'b0;
      softRst_q <= 1'b0;
    end else begin
      lock_q    <= lock_q | (wrStatus & regWrData[STAT_LOCK]);
      softRst_q <= wrStatus & regWrData[STAT_SOFTRST];
    end
  end

  // delay count decode; long counts are parameters so a bench can shrink them
  always_comb begin
    case (cfgB_q[CFGB_OCT_HI:CFGB_OCT_LO])
      OCT_SEL0: ocCycles_d = OC_CNT_W'(OC_CYC0);
      OCT_SEL1: ocCycles_d = OC_CNT_W'(OC_CYC1);
      OCT_SEL2: ocCycles_d = OC_CNT_W'(OC_CYC2);
      OCT_SEL3: ocCycles_d = OC_CNT_W'(OC_CYC3);
      default:  ocCycles_d = OC_CNT_W'(OC_CYC0);
    endcase
  end

  // read mux; unmapped offsets read zero, reserved bits were never stored
  always_comb begin
    case (regAddr)
      ADDR_STATUS: rdData_d = {5'h00, softRst_q, lock_q, 1'b0};
      ADDR_CFG_A:  rdData_d = cfgA_q;
      ADDR_CFG_B:  rdData_d = cfgB_q;
      ADDR_FIXED:  rdData_d = fixedMask_q;
      ADDR_SPOFF:  rdData_d = spOffMask_q;
      default:     rdData_d = REG_RST;
    endcase
  end

  // derived outputs and read data, registered so every output leaves from a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_q      <= REG_RST;
      selfPowered_q <= 1'b0;
      ocCycles_q    <= '0;
      gapErr_q      <= 1'b0;
    end else begin
      rdData_q      <= regRdEn ? rdData_d : rdData_q;
      selfPowered_q <= effSelfPowered;
      ocCycles_q    <= ocCycles_d;
      gapErr_q      <= hasGap(spOffMask_q[PORT_LSB +: PORT_CNT]);
    end
  end

  // field outputs come directly from the storage flops
  assign regRdData             = rdData_q;
  assign selfPowered           = selfPowered_q;
  assign supplySourceSel       = cfgA_q[CFGA_SUPPLY];
  assign ledIndicatorSupport   = cfgA_q[CFGA_LED];
  assign fullSpeedOnly         = cfgA_q[CFGA_FSONLY];
  assign perPortTranslatorEn   = cfgA_q[CFGA_PPTT];
  assign fsFrameEndSuppress    = cfgA_q[CFGA_EOPSUP];
  assign overcurrentSenseMode  = cfgA_q[CFGA_OCS_HI:CFGA_OCS_LO];
  assign overcurrentSenseOff   = cfgA_q[CFGA_OCS_HI];
  assign powerSwitchMode       = cfgA_q[CFGA_PWRSW];
  assign dynamicSwitchEn       = cfgB_q[CFGB_DYN];
  assign overcurrentDelaySel   = cfgB_q[CFGB_OCT_HI:CFGB_OCT_LO];
  assign overcurrentDelayCycles = ocCycles_q;
  assign compoundDevice        = cfgB_q[CFGB_CMPND];
  assign fixedPortMask         = fixedMask_q[PORT_LSB +: PORT_CNT];
  assign selfSupplyPortOffMask = spOffMask_q[PORT_LSB +: PORT_CNT];
  assign portOffGapErr         = gapErr_q;
  assign configLock            = lock_q;
  assign serialIfReset         = softRst_q;

  // ---- checks ----
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_softResetReq;
    regWrEn && !softRst_q && (regAddr == ADDR_STATUS) && regWrData[STAT_SOFTRST];
  endsequence

  sequence s_lockedCfgWrite;
    lock_q && !softRst_q && regWrEn && (regAddr >= ADDR_CFG_A) && (regAddr <= ADDR_SPOFF);
  endsequence

  sequence s_pinLowDynamic;
    cfgB_q[CFGB_DYN] && !pinSupply;
  endsequence

  a_soft_rst_seq: assert property (s_softResetReq |=> softRst_q ##1 (!softRst_q && cfgA_q == REG_RST
      && cfgB_q == REG_RST && fixedMask_q == REG_RST && spOffMask_q == REG_RST))
    else $error("soft reset did not clear registers or itself");

  a_soft_rst_keeps_lock: assert property (softRst_q && lock_q |=> lock_q)
    else $error("soft reset dropped the lock");

  a_lock_blocks_write: assert property (s_lockedCfgWrite |=> $stable(cfgA_q) && $stable(cfgB_q)
      && $stable(fixedMask_q) && $stable(spOffMask_q))
    else $error("write accepted while locked");

  a_write_visible: assert property (regWrEn && !lock_q && !softRst_q && regAddr == ADDR_CFG_A
      |=> fullSpeedOnly == $past(regWrData[CFGA_FSONLY])
      && overcurrentSenseMode == $past(regWrData[CFGA_OCS_HI:CFGA_OCS_LO]))
    else $error("first config byte write not visible on outputs");

  a_dynamic_pin: assert property (s_pinLowDynamic [*2] |-> !selfPowered_q)
    else $error("dynamic switching ignored the supply pin");

  a_static_supply: assert property (!cfgB_q[CFGB_DYN] && cfgA_q[CFGA_SUPPLY] ##1 $stable(cfgB_q)
      && $stable(cfgA_q) |-> selfPowered_q)
    else $error("self power not reported from supply bit");

  a_mask_reserved_zero: assert property (regRdEn && (regAddr == ADDR_FIXED || regAddr == ADDR_SPOFF)
      |=> (regRdData & ~PORT_WMASK) == REG_RST)
    else $error("reserved port mask bits read nonzero");

  a_cfgb_reserved_zero: assert property (regRdEn && regAddr == ADDR_CFG_B
      |=> (regRdData & ~CFGB_WMASK) == REG_RST)
    else $error("reserved second byte bits read nonzero");

  a_delay_short: assert property (overcurrentDelaySel == OCT_SEL0 ##1 overcurrentDelaySel == OCT_SEL0
      |-> overcurrentDelayCycles == OC_CNT_W'(OC_CYC0))
    else $error("overcurrent delay count wrong for shortest setting");

  a_delay_long: assert property (overcurrentDelaySel == OCT_SEL3 ##1 overcurrentDelaySel == OCT_SEL3
      |-> overcurrentDelayCycles == OC_CNT_W'(OC_CYC3))
    else $error("overcurrent delay count wrong for longest setting");

  a_gap_flag: assert property (selfSupplyPortOffMask == 4'h5 |=> portOffGapErr)
    else $error("non-contiguous port-off mask not flagged");

endmodule

// file: tb/hcb_host_model.sv
// register host model that loads configuration bytes one request at a time
`timescale 1ns/1ps
module hcb_host_model
  import hcb_pkg::*;
(
  input  wire logic              ref_clk,
  output logic      [ADDR_W-1:0] regAddr,
  output logic                   regWrEn,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regRdEn
);
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end

  // a released bus shows inverted leftovers so stale values never look valid
  task automatic idle();
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = ~regAddr;
    regWrData = ~regWrData;
  endtask

  // one write, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge ref_clk);
    idle();
  endtask

  // one read request, data lands after the taking edge
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge ref_clk);
    idle();
  endtask

  // no-sensing code is only loaded into a bus-powered setup
  function automatic logic [7:0] cfg_a_legal(input logic [7:0] d);
    return d[CFGA_SUPPLY] ? (d & 8'hFB) : d;
  endfunction
endmodule

// file: tb/tb_top.sv
// self-checking bench for the hub configuration byte bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); err_count++; end end
module tb_top
  import hcb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, rdPend = 1'b0;
  logic localSupplyPresent = 1'b0;
  logic selfPowered, supplySourceSel, ledIndicatorSupport, fullSpeedOnly, perPortTranslatorEn;
  logic fsFrameEndSuppress, overcurrentSenseOff, powerSwitchMode, dynamicSwitchEn, compoundDevice;
  logic portOffGapErr, configLock, serialIfReset;
  logic [1:0] overcurrentSenseMode, overcurrentDelaySel;
  logic [15:0] overcurrentDelayCycles;
  logic [3:0] fixedPortMask, selfSupplyPortOffMask;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h35;
  logic [7:0] expQ[$];
  logic [7:0] expRd;
  int ocTab[4] = '{10, 20, 40, 60};

  always #50 ref_clk = ~ref_clk;

  hcb_host_model u_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn));

  hcb_config_bank #(.OC_CYC0(10), .OC_CYC1(20), .OC_CYC2(40), .OC_CYC3(60)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .localSupplyPresent(localSupplyPresent),
    .selfPowered(selfPowered), .supplySourceSel(supplySourceSel), .ledIndicatorSupport(ledIndicatorSupport),
    .fullSpeedOnly(fullSpeedOnly), .perPortTranslatorEn(perPortTranslatorEn),
    .fsFrameEndSuppress(fsFrameEndSuppress), .overcurrentSenseMode(overcurrentSenseMode),
    .overcurrentSenseOff(overcurrentSenseOff), .powerSwitchMode(powerSwitchMode),
    .dynamicSwitchEn(dynamicSwitchEn), .overcurrentDelaySel(overcurrentDelaySel),
    .overcurrentDelayCycles(overcurrentDelayCycles), .compoundDevice(compoundDevice),
    .fixedPortMask(fixedPortMask), .selfSupplyPortOffMask(selfSupplyPortOffMask),
    .portOffGapErr(portOffGapErr), .configLock(configLock), .serialIfReset(serialIfReset));

  // read monitor: data is settled by the falling edge after the taking edge
  always @(posedge ref_clk) rdPend <= regRdEn;
  always @(negedge ref_clk) begin
    if (rdPend) begin
      if (expQ.size() == 0) begin
        $display("MISMATCH regRdData expected queued value seen %h", regRdData);
        err_count++;
      end else begin
        // pop once: the compare macro repeats its expected argument in the message
        expRd = expQ.pop_front();
        `CHK("regRdData", expRd, regRdData)
      end
    end
  end

  function automatic logic [7:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // contiguous or empty port groups are the legal disable patterns
  function automatic logic contig(input logic [3:0] m);
    logic [3:0] s;
    s = m;
    if (s == 4'h0) return 1'b1;
    while (!s[0]) s = s >> 1;
    return ((s + 4'h1) & s) == 4'h0;
  endfunction

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    u_host.rd(a);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [7:0] a, b, f, p;
    int n;
    do_reset();
    // every configuration byte comes up clear
    foreach (ocTab[i]) rdx(ADDR_CFG_A + 8'(i), 8'h00);
    `CHK("configLock", 1'b0, configLock)
    $display("test reset done");
    // random loads, decoded outputs and read-back with reserved bits dropped
    for (int i = 0; i < 12; i++) begin
      a = u_host.cfg_a_legal(xrand());
      b = xrand();
      f = xrand();
      p = xrand();
      localSupplyPresent = xrand() > 8'h7F;
      u_host.wr(ADDR_CFG_A, a);
      u_host.wr(ADDR_CFG_B, b);
      u_host.wr(ADDR_FIXED, f);
      u_host.wr(ADDR_SPOFF, p);
      @(negedge ref_clk);
      `CHK("supplySourceSel", a[7], supplySourceSel)
      `CHK("selfPowered", b[7] ? localSupplyPresent : a[7], selfPowered)
      `CHK("ledIndicatorSupport", a[6], ledIndicatorSupport)
      `CHK("fullSpeedOnly", a[5], fullSpeedOnly)
      `CHK("perPortTranslatorEn", a[4], perPortTranslatorEn)
      `CHK("fsFrameEndSuppress", a[3], fsFrameEndSuppress)
      `CHK("overcurrentSenseMode", a[2:1], overcurrentSenseMode)
      `CHK("overcurrentSenseOff", a[2], overcurrentSenseOff)
      `CHK("powerSwitchMode", a[0], powerSwitchMode)
      `CHK("dynamicSwitchEn", b[7], dynamicSwitchEn)
      `CHK("overcurrentDelaySel", b[5:4], overcurrentDelaySel)
      `CHK("overcurrentDelayCycles", 16'(ocTab[b[5:4]]), overcurrentDelayCycles)
      `CHK("compoundDevice", b[3], compoundDevice)
      `CHK("fixedPortMask", f[4:1], fixedPortMask)
      `CHK("selfSupplyPortOffMask", p[4:1], selfSupplyPortOffMask)
      `CHK("portOffGapErr", !contig(p[4:1]), portOffGapErr)
      rdx(ADDR_CFG_A, a);
      rdx(ADDR_CFG_B, b & 8'hB8);
      rdx(ADDR_FIXED, f & 8'h1E);
      rdx(ADDR_SPOFF, p & 8'h1E);
    end
    $display("test random loads done");
    // dynamic switching follows the supply pin after its synchroniser
    u_host.wr(ADDR_CFG_A, 8'h00);
    u_host.wr(ADDR_CFG_B, 8'h80);
    for (int k = 0; k < 2; k++) begin
      localSupplyPresent = ~localSupplyPresent;
      repeat (8) @(negedge ref_clk);
      `CHK("selfPowered", localSupplyPresent, selfPowered)
    end
    // a split port-off group must raise the gap flag one edge after the write
    u_host.wr(ADDR_SPOFF, 8'h0A);
    @(negedge ref_clk);
    `CHK("portOffGapErr", 1'b1, portOffGapErr)
    $display("test dynamic supply done");
    // soft reset pulses the serial reset and clears all four bytes
    u_host.wr(ADDR_CFG_A, 8'h5A);
    u_host.wr(ADDR_STATUS, 8'h04);
    n = 0;
    while (serialIfReset !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    if (serialIfReset !== 1'b1) begin
      $display("MISMATCH serialIfReset expected 1 seen %b", serialIfReset);
      err_count++;
      final_report();
    end
    foreach (ocTab[i]) rdx(ADDR_CFG_A + 8'(i), 8'h00);
    `CHK("serialIfReset", 1'b0, serialIfReset)
    $display("test soft reset done");
    // lock blocks configuration writes until the reset pin, unmapped reads zero
    u_host.wr(ADDR_STATUS, 8'h02);
    `CHK("configLock", 1'b1, configLock)
    u_host.wr(ADDR_CFG_A, 8'hFF);
    u_host.wr(ADDR_SPOFF, 8'h1E);
    rdx(ADDR_CFG_A, 8'h00);
    rdx(ADDR_SPOFF, 8'h00);
    // soft reset while locked must leave the lock standing
    u_host.wr(ADDR_STATUS, 8'h04);
    `CHK("configLock", 1'b1, configLock)
    rdx(8'h20, 8'h00);
    // let the read monitor finish before reset clears the read data
    @(negedge ref_clk);
    do_reset();
    `CHK("configLock", 1'b0, configLock)
    u_host.wr(ADDR_CFG_A, 8'h20);
    `CHK("fullSpeedOnly", 1'b1, fullSpeedOnly)
    rdx(ADDR_CFG_A, 8'h20);
    repeat (2) @(negedge ref_clk);
    $display("test lock done");
    final_report();
  end
endmodule
